// [verilog/fbm_pkg.sv]
// Constants, types and the expected query table for the flash bank mode controller.
`default_nettype none
package fbm_pkg;
	localparam int FBM_CLK_NS = 20;
	localparam int FBM_T_WP_NS = 40;
	localparam int FBM_T_ACC_NS = 90;
	localparam int FBM_WP_CYC = (FBM_T_WP_NS + FBM_CLK_NS - 1) / FBM_CLK_NS;
	localparam int FBM_ACC_CYC = (FBM_T_ACC_NS + FBM_CLK_NS - 1) / FBM_CLK_NS;
	localparam int FBM_FETCH_CYC = 2;
	localparam int FBM_SYNC_CYC = 2;
	localparam int FBM_AW = 23;
	localparam int FBM_DW = 16;
	localparam int FBM_NB = 4;
	localparam int FBM_QN = 16;
	localparam int FBM_QIDX_W = 4;
	localparam logic [2:0] FBM_REG_CTRL = 3'h0;
	localparam logic [2:0] FBM_REG_ADDR = 3'h1;
	localparam logic [2:0] FBM_REG_WDATA = 3'h2;
	localparam logic [2:0] FBM_REG_STATUS = 3'h3;
	localparam logic [2:0] FBM_REG_RDATA = 3'h4;
	localparam int FBM_CTRL_OP_LSB = 0;
	localparam int FBM_CTRL_BANK_LSB = 3;
	localparam int FBM_CTRL_BYTE_BIT = 5;
	localparam int FBM_ST_SEQ = 0;
	localparam int FBM_ST_DEV = 1;
	localparam int FBM_ST_REF = 2;
	localparam int FBM_ST_TMO = 3;
	localparam int FBM_ST_QF = 4;
	localparam int FBM_ST_QD = 5;
	localparam int FBM_ST_AS_LSB = 6;
	localparam int FBM_TMO_BIT = 5;
	localparam logic [FBM_AW-1:0] FBM_ADDR_RST = 23'h000000;
	localparam logic [FBM_DW-1:0] FBM_DATA_RST = 16'h0000;
	localparam logic [FBM_AW-1:0] FBM_UNLOCK1_ADDR = 23'h000001;
	localparam logic [FBM_AW-1:0] FBM_UNLOCK2_ADDR = 23'h000002;
	localparam logic [FBM_AW-1:0] FBM_QUERY_ADDR = 23'h000003;
	localparam logic [FBM_DW-1:0] FBM_UNLOCK1_DATA = 16'h0011;
	localparam logic [FBM_DW-1:0] FBM_UNLOCK2_DATA = 16'h0022;
	localparam logic [FBM_DW-1:0] FBM_AUTOSEL_CMD = 16'h0044;
	localparam logic [FBM_DW-1:0] FBM_RESET_CMD = 16'h00EE;
	localparam logic [FBM_DW-1:0] FBM_QUERY_CMD = 16'h00CC;

	typedef enum logic [2:0] {
		FBM_OP_READ = 3'b000,
		FBM_OP_RAWWR = 3'b001,
		FBM_OP_RESET = 3'b010,
		FBM_OP_AUTOSEL = 3'b011,
		FBM_OP_ASREAD = 3'b100,
		FBM_OP_QCHECK = 3'b101
	} fbm_op_t;

	typedef enum logic [2:0] {
		FBM_S_IDLE = 3'b000,
		FBM_S_FETCH = 3'b001,
		FBM_S_SETUP = 3'b010,
		FBM_S_WLOW = 3'b011,
		FBM_S_WHOLD = 3'b100,
		FBM_S_RLOW = 3'b101,
		FBM_S_RCAP = 3'b110,
		FBM_S_GAP = 3'b111
	} fbm_st_t;

	typedef struct packed {
		logic wr;
		logic [FBM_AW-1:0] addr;
		logic [FBM_DW-1:0] data;
	} fbm_cyc_t;

	typedef struct packed {
		logic [7:0] ofs;
		logic [FBM_DW-1:0] val;
	} fbm_qent_t;

	// Word offsets and the values the part must return for them.
	localparam fbm_qent_t FBM_QTAB [FBM_QN] = '{
		'{8'h15, 16'h0040},
		'{8'h45, 16'h000C},
		'{8'h46, 16'h0002},
		'{8'h47, 16'h0001},
		'{8'h48, 16'h0001},
		'{8'h49, 16'h0004},
		'{8'h4A, 16'h0077},
		'{8'h4B, 16'h0000},
		'{8'h4C, 16'h0000},
		'{8'h4F, 16'h0001},
		'{8'h50, 16'h0000},
		'{8'h57, 16'h0004},
		'{8'h58, 16'h0017},
		'{8'h59, 16'h0030},
		'{8'h5A, 16'h0030},
		'{8'h5B, 16'h0017}
	};
endpackage
`default_nettype wire

// [verilog/fbm_qrom.sv]
// Registered lookup of the expected query table entries.
`timescale 1ns/1ps
`default_nettype none
module fbm_qrom
	import fbm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [FBM_QIDX_W-1:0] idx,
	output var fbm_qent_t q
);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= FBM_QTAB[idx];
		end
	end
endmodule // fbm_qrom
`default_nettype wire

// [verilog/fbm_ctrl.sv]
// Host-side controller that drives the flash pins and tracks per-bank modes.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Command cycles go out only in the fixed order of each sequence.
// - Host issues reset after a timeout error or to leave autoselect.
// - Autoselect only to idle banks, never while another bank is busy.
// - Autoselect is two unlock writes then bank address with the command.
// - Protection reads put bank and sector address on the bus together.
module fbm_ctrl
	import fbm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [2:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [FBM_AW-1:0] pin_addr,
	input wire logic [FBM_DW-1:0] pin_dq_in,
	output logic [FBM_DW-1:0] pin_dq_out,
	output logic pin_dq_oe,
	output logic pin_ce_n,
	output logic pin_we_n,
	output logic pin_oe_n,
	output logic pin_byte_n,
	input wire logic ready_busy_out_n
);
	function automatic logic [4:0] fbm_len(input fbm_op_t op);
		case (op)
			FBM_OP_AUTOSEL: fbm_len = 5'h03;
			FBM_OP_QCHECK: fbm_len = 5'(FBM_QN + 2);
			default: fbm_len = 5'h01;
		endcase
	endfunction

	function automatic fbm_cyc_t fbm_cycle(input fbm_op_t op, input logic [4:0] step,
		input logic [FBM_AW-1:0] a, input logic [FBM_DW-1:0] d, input logic [7:0] ofs,
		input logic byte_mode);
		fbm_cyc_t c;
		c.wr = 1'b1;
		c.addr = a;
		c.data = d;
		case (op)
			FBM_OP_READ, FBM_OP_ASREAD: c.wr = 1'b0;
			FBM_OP_RESET: c.data = FBM_RESET_CMD;
			FBM_OP_AUTOSEL: begin
				if (step == 5'h00) begin
					c.addr = FBM_UNLOCK1_ADDR;
					c.data = FBM_UNLOCK1_DATA;
				end else if (step == 5'h01) begin
					c.addr = FBM_UNLOCK2_ADDR;
					c.data = FBM_UNLOCK2_DATA;
				end else begin
					c.data = FBM_AUTOSEL_CMD;
				end
			end
			FBM_OP_QCHECK: begin
				if (step == 5'h00) begin
					c.addr = FBM_QUERY_ADDR;
					c.data = FBM_QUERY_CMD;
				end else if (step == 5'(FBM_QN + 1)) begin
					c.data = FBM_RESET_CMD;
				end else begin
					c.wr = 1'b0;
					c.addr = byte_mode ? {14'h0000, ofs, 1'b0} : {15'h0000, ofs};
				end
			end
			default: c.wr = 1'b0;
		endcase
		return c;
	endfunction

	fbm_st_t st;
	fbm_st_t next_st;
	fbm_op_t cur_op;
	fbm_op_t ctrl_op;
	fbm_cyc_t cyc;
	fbm_qent_t qent;
	logic [1:0] ctrl_bank;
	logic [1:0] cur_bank;
	logic ctrl_byte;
	logic [FBM_AW-1:0] addr_reg;
	logic [FBM_DW-1:0] wdata_reg;
	logic [FBM_DW-1:0] rdata_reg;
	logic [4:0] step;
	logic [3:0] cnt;
	logic [2:0] wr_cnt;
	logic go;
	logic auto_rst;
	logic [FBM_NB-1:0] bank_as;
	logic refused;
	logic tmo;
	logic qfail;
	logic qdone;
	logic rb_s1, rb_s2, rb_s3, rb_lvl;
	logic [FBM_DW-1:0] dq_s1, dq_s2, dq_s3;
	logic dev_busy, allowed, start_auto, start_sw, refuse_now, last, capture, done;
	logic ctrl_wr, stat_wr;

	fbm_qrom u_qrom (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.idx(FBM_QIDX_W'(step - 5'h01)),
		.q(qent)
	);

	// Three-stage synchronisers; only stage three and the stage-two/three agreement are used.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rb_s1 <= 1'b1;
			rb_s2 <= 1'b1;
			rb_s3 <= 1'b1;
			rb_lvl <= 1'b1;
			dq_s1 <= '0;
			dq_s2 <= '0;
			dq_s3 <= '0;
		end else begin
			rb_s1 <= ready_busy_out_n;
			rb_s2 <= rb_s1;
			rb_s3 <= rb_s2;
			if (rb_s2 == rb_s3) begin
				rb_lvl <= rb_s3;
			end
			dq_s1 <= pin_dq_in;
			dq_s2 <= dq_s1;
			dq_s3 <= dq_s2;
		end
	end

	assign dev_busy = !rb_lvl;
	assign ctrl_wr = reg_wr && reg_addr == FBM_REG_CTRL;
	assign stat_wr = reg_wr && reg_addr == FBM_REG_STATUS;
	assign last = step == fbm_len(cur_op) - 5'h01;
	assign capture = st == FBM_S_RCAP && dq_s2 == dq_s3;
	assign done = st == FBM_S_GAP && last;

	always_comb begin
		case (ctrl_op)
			FBM_OP_READ, FBM_OP_RAWWR: allowed = !bank_as[ctrl_bank];
			FBM_OP_RESET: allowed = 1'b1;
			FBM_OP_AUTOSEL: allowed = !dev_busy && !bank_as[ctrl_bank];
			FBM_OP_ASREAD: allowed = bank_as[ctrl_bank];
			FBM_OP_QCHECK: allowed = !dev_busy && bank_as == '0;
			default: allowed = 1'b0;
		endcase
	end

	assign start_auto = st == FBM_S_IDLE && auto_rst;
	assign start_sw = st == FBM_S_IDLE && !auto_rst && go && allowed;
	assign refuse_now = (st == FBM_S_IDLE && !auto_rst && go && !allowed) ||
		(ctrl_wr && (st != FBM_S_IDLE || go));

	always_comb begin
		next_st = st;
		case (st)
			FBM_S_IDLE: if (start_auto || start_sw) next_st = FBM_S_FETCH;
			FBM_S_FETCH: if (cnt == 4'(FBM_FETCH_CYC - 1)) next_st = FBM_S_SETUP;
			FBM_S_SETUP: next_st = cyc.wr ? FBM_S_WLOW : FBM_S_RLOW;
			FBM_S_WLOW: if (cnt == 4'(FBM_WP_CYC - 1)) next_st = FBM_S_WHOLD;
			FBM_S_WHOLD: next_st = FBM_S_GAP;
			FBM_S_RLOW: if (cnt == 4'(FBM_ACC_CYC + FBM_SYNC_CYC - 1)) next_st = FBM_S_RCAP;
			FBM_S_RCAP: if (dq_s2 == dq_s3) next_st = FBM_S_GAP;
			FBM_S_GAP: next_st = last ? FBM_S_IDLE : FBM_S_FETCH;
			default: next_st = FBM_S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= FBM_S_IDLE;
			cnt <= 4'h0;
			step <= 5'h00;
			cur_op <= FBM_OP_READ;
			cur_bank <= 2'h0;
		end else begin
			st <= next_st;
			cnt <= (next_st != st) ? 4'h0 : cnt + 4'h1;
			if (start_auto) begin
				cur_op <= FBM_OP_RESET;
			end else if (start_sw) begin
				cur_op <= ctrl_op;
				cur_bank <= ctrl_bank;
			end
			if (start_auto || start_sw) begin
				step <= 5'h00;
			end else if (st == FBM_S_GAP && !last) begin
				step <= step + 5'h01;
			end
		end
	end

	// The cycle is frozen on entry to setup so address and data stay put for the whole strobe.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc <= '0;
		end else if (st == FBM_S_FETCH && next_st == FBM_S_SETUP) begin
			cyc <= fbm_cycle(cur_op, step, addr_reg, wdata_reg, qent.ofs, !pin_byte_n);
		end
	end

	// Chip enable opens before write enable and closes a cycle after it, so both edges fall inside it.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_addr <= FBM_ADDR_RST;
			pin_dq_out <= FBM_DATA_RST;
			pin_dq_oe <= 1'b0;
			pin_ce_n <= 1'b1;
			pin_we_n <= 1'b1;
			pin_oe_n <= 1'b1;
			pin_byte_n <= 1'b1;
		end else begin
			if (next_st == FBM_S_SETUP) begin
				pin_addr <= fbm_cycle(cur_op, step, addr_reg, wdata_reg, qent.ofs, !pin_byte_n).addr;
				pin_dq_out <= fbm_cycle(cur_op, step, addr_reg, wdata_reg, qent.ofs, !pin_byte_n).data;
			end
			pin_dq_oe <= (next_st == FBM_S_SETUP && st == FBM_S_FETCH) ? (cur_op != FBM_OP_READ &&
				cur_op != FBM_OP_ASREAD && fbm_cycle(cur_op, step, addr_reg, wdata_reg, qent.ofs,
				!pin_byte_n).wr) : (pin_dq_oe && next_st != FBM_S_GAP && next_st != FBM_S_IDLE);
			pin_ce_n <= !(next_st inside {FBM_S_SETUP, FBM_S_WLOW, FBM_S_WHOLD, FBM_S_RLOW, FBM_S_RCAP});
			pin_we_n <= next_st != FBM_S_WLOW;
			pin_oe_n <= !(next_st inside {FBM_S_RLOW, FBM_S_RCAP});
			if (st == FBM_S_IDLE) begin
				pin_byte_n <= !ctrl_byte;
			end
		end
	end

	// Software registers; a control write is taken only when the sequencer is idle and no order is waiting, even with an automatic reset pending.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_op <= FBM_OP_READ;
			ctrl_bank <= 2'h0;
			ctrl_byte <= 1'b0;
			addr_reg <= FBM_ADDR_RST;
			wdata_reg <= FBM_DATA_RST;
			go <= 1'b0;
		end else begin
			if (ctrl_wr && st == FBM_S_IDLE && !go) begin
				ctrl_op <= fbm_op_t'(reg_wdata[FBM_CTRL_OP_LSB +: 3]);
				ctrl_bank <= reg_wdata[FBM_CTRL_BANK_LSB +: 2];
				ctrl_byte <= reg_wdata[FBM_CTRL_BYTE_BIT];
				go <= 1'b1;
			end else if (start_sw || (st == FBM_S_IDLE && !auto_rst && go)) begin
				go <= 1'b0;
			end
			if (reg_wr && reg_addr == FBM_REG_ADDR) begin
				addr_reg <= reg_wdata[FBM_AW-1:0];
			end
			if (reg_wr && reg_addr == FBM_REG_WDATA) begin
				wdata_reg <= reg_wdata[FBM_DW-1:0];
			end
		end
	end

	// Bank mode view: reset and power-up leave every bank reading array data.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bank_as <= '0;
		end else if (done && cur_op == FBM_OP_AUTOSEL) begin
			bank_as[cur_bank] <= 1'b1;
		end else if (done && (cur_op == FBM_OP_RESET || cur_op == FBM_OP_QCHECK)) begin
			bank_as <= '0;
		end
	end

	// Sticky flags; a hardware set in the same cycle as a software clear wins.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			refused <= 1'b0;
			tmo <= 1'b0;
			qfail <= 1'b0;
			qdone <= 1'b0;
			auto_rst <= 1'b0;
			rdata_reg <= FBM_DATA_RST;
		end else begin
			refused <= refuse_now || (refused && !(stat_wr && reg_wdata[FBM_ST_REF]));
			// A busy part showing the timeout flag holds its busy pin until a reset is written.
			if (capture && (cur_op == FBM_OP_READ || cur_op == FBM_OP_ASREAD) && dev_busy &&
				dq_s3[FBM_TMO_BIT]) begin
				tmo <= 1'b1;
				auto_rst <= 1'b1;
			end else begin
				tmo <= tmo && !(stat_wr && reg_wdata[FBM_ST_TMO]);
				auto_rst <= auto_rst && !start_auto;
			end
			if (capture && cur_op == FBM_OP_QCHECK && (pin_byte_n ? dq_s3 != qent.val :
				dq_s3[7:0] != qent.val[7:0])) begin
				qfail <= 1'b1;
			end else begin
				qfail <= qfail && !(stat_wr && reg_wdata[FBM_ST_QF]);
			end
			qdone <= (done && cur_op == FBM_OP_QCHECK) || (qdone && !(stat_wr && reg_wdata[FBM_ST_QD]));
			if (capture && cur_op != FBM_OP_QCHECK) begin
				rdata_reg <= dq_s3;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				FBM_REG_CTRL: reg_rdata <= 32'({ctrl_byte, ctrl_bank, ctrl_op});
				FBM_REG_ADDR: reg_rdata <= 32'(addr_reg);
				FBM_REG_WDATA: reg_rdata <= 32'(wdata_reg);
				FBM_REG_STATUS: reg_rdata <= 32'({bank_as, qdone, qfail, tmo, refused, dev_busy,
					st != FBM_S_IDLE || go || auto_rst});
				FBM_REG_RDATA: reg_rdata <= 32'(rdata_reg);
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_cnt <= 3'h0;
		end else if (start_auto || start_sw) begin
			wr_cnt <= 3'h0;
		end else if (st == FBM_S_WLOW && cnt == 4'h0) begin
			wr_cnt <= wr_cnt + 3'h1;
		end
	end

	default clocking fbm_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	chk_we_in_ce: assert property (!pin_we_n |-> !pin_ce_n) else $error("write strobe outside chip enable");
	chk_we_oe_excl: assert property (!pin_we_n |-> pin_oe_n) else $error("write and read strobes overlap");
	chk_addr_stable: assert property (!pin_we_n |-> $stable(pin_addr)) else $error("address moved in write");
	chk_data_hold: assert property ($rose(pin_we_n) |-> pin_dq_oe && $stable(pin_dq_out))
		else $error("data not held at write strobe rise");
	chk_autosel_gate: assert property (start_sw && ctrl_op == FBM_OP_AUTOSEL |-> !dev_busy && !bank_as[ctrl_bank])
		else $error("autoselect started on busy part");
	chk_autosel_three: assert property (done && cur_op == FBM_OP_AUTOSEL |-> wr_cnt == 3'h3)
		else $error("autoselect did not use three writes");
	chk_timeout_reset: assert property ($rose(tmo) |-> ##[1:40] (cur_op == FBM_OP_RESET && !pin_we_n))
		else $error("no reset written after timeout");
	chk_asread_gate: assert property (start_sw && ctrl_op == FBM_OP_ASREAD |-> bank_as[ctrl_bank])
		else $error("id read outside autoselect");
	chk_reset_clears: assert property (done && cur_op == FBM_OP_RESET |=> bank_as == '0)
		else $error("reset left a bank in autoselect");
	chk_byte_qaddr: assert property (cur_op == FBM_OP_QCHECK && !pin_oe_n && !pin_byte_n |-> !pin_addr[0])
		else $error("odd byte address in query read");
endmodule // fbm_ctrl
`default_nettype wire

// [tb/fbm_flash_model.sv]
// Behavioural pin-level model of the multi-bank flash driven by the controller.
`timescale 1ns/1ps
`default_nettype none
module fbm_flash_model
	import fbm_pkg::*;
#(
	parameter logic [15:0] MAKER_ID = 16'h00A1
)
(
	input wire logic [FBM_AW-1:0] addr,
	input wire logic [FBM_DW-1:0] dq_in,
	output logic [FBM_DW-1:0] dq_out,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic byte_n,
	input wire logic busy,
	input wire logic fail,
	output logic rb_n,
	output logic [FBM_NB-1:0] as_mode,
	output logic tmo
);
	// MAKER_ID is an arbitrary value, not any real maker's code.
	logic [FBM_AW-1:0] a_lat;
	logic [FBM_AW-1:0] wa;
	logic [1:0] step = 2'd0;
	logic qmode = 1'b0;
	logic [15:0] val;
	logic [15:0] lastv = 16'h0000;
	wire wstb = we_n | ce_n;

	function automatic logic [15:0] qval(input logic [7:0] o);
		case (o)
			8'h15: qval = 16'h0040;
			8'h45: qval = 16'h000C;
			8'h46: qval = 16'h0002;
			8'h47, 8'h48: qval = 16'h0001;
			8'h49, 8'h57: qval = 16'h0004;
			8'h4A: qval = 16'h0077;
			8'h4F: qval = 16'h0001;
			8'h58, 8'h5B: qval = 16'h0017;
			8'h59, 8'h5A: qval = 16'h0030;
			default: qval = 16'h0000;
		endcase
	endfunction

	initial begin
		as_mode = '0;
		tmo = 1'b0;
	end
	always @(posedge fail) tmo = 1'b1;
	always @(negedge wstb) a_lat = addr;
	// Data is taken when the first of the two strobes rises.
	always @(posedge wstb) begin
		// A reset between the cycles of any sequence drops the partial sequence.
		if (dq_in == FBM_RESET_CMD) begin
			as_mode = '0;
			step = 2'd0;
			qmode = 1'b0;
			tmo = 1'b0;
		end else if (!tmo) begin
			case (step)
				2'd0: begin
					if (a_lat == FBM_UNLOCK1_ADDR && dq_in == FBM_UNLOCK1_DATA) step = 2'd1;
					else if (a_lat == FBM_QUERY_ADDR && dq_in == FBM_QUERY_CMD) qmode = 1'b1;
				end
				2'd1: step = (a_lat == FBM_UNLOCK2_ADDR && dq_in == FBM_UNLOCK2_DATA) ? 2'd2 : 2'd0;
				default: begin
					if (dq_in == FBM_AUTOSEL_CMD) as_mode[a_lat[21:20]] = 1'b1;
					step = 2'd0;
				end
			endcase
		end
	end
	assign wa = byte_n ? addr : {1'b0, addr[FBM_AW-1:1]};
	always @* begin
		if (tmo) val = 16'h0001 << FBM_TMO_BIT;
		else if (qmode) val = qval(wa[7:0]) & (byte_n ? 16'hFFFF : 16'h00FF);
		else if (as_mode[wa[21:20]]) val = MAKER_ID;
		// Erase suspend is not modelled, so every sector reads array data.
		else val = wa[15:0] ^ 16'hA5C3;
		if (!ce_n && !oe_n) lastv = val;
	end
	// A released bus shows the inverse of its last value, so a late capture cannot pass by luck.
	assign dq_out = (!ce_n && !oe_n) ? val : ~lastv;
	// Busy stands for an embedded algorithm; when it ends, array reads resume with no command.
	assign rb_n = !(busy || tmo);
endmodule // fbm_flash_model
`default_nettype wire

// [tb/fbm_ctrl_test.sv]
// Self-checking register-level bench for the flash bank mode controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module fbm_ctrl_test
	import fbm_pkg::*;
;
	logic core_clk;
	logic rst_b;
	logic [2:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [FBM_AW-1:0] pin_addr;
	logic [FBM_DW-1:0] pin_dq_in;
	logic [FBM_DW-1:0] pin_dq_out;
	logic pin_dq_oe;
	logic pin_ce_n;
	logic pin_we_n;
	logic pin_oe_n;
	logic pin_byte_n;
	logic ready_busy_out_n;
	logic busy;
	logic fail;
	logic [FBM_NB-1:0] as_mode;
	logic tmo;
	logic [31:0] v;
	int n_fail;
	int total_checks;

	fbm_ctrl i_fbm_ctrl (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_addr(pin_addr), .pin_dq_in(pin_dq_in),
		.pin_dq_out(pin_dq_out), .pin_dq_oe(pin_dq_oe), .pin_ce_n(pin_ce_n), .pin_we_n(pin_we_n),
		.pin_oe_n(pin_oe_n), .pin_byte_n(pin_byte_n), .ready_busy_out_n(ready_busy_out_n));
	fbm_flash_model i_fbm_flash_model (.addr(pin_addr), .dq_in(pin_dq_out), .dq_out(pin_dq_in), .ce_n(pin_ce_n),
		.we_n(pin_we_n), .oe_n(pin_oe_n), .byte_n(pin_byte_n), .busy(busy), .fail(fail),
		.rb_n(ready_busy_out_n), .as_mode(as_mode), .tmo(tmo));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	// Issues one order and polls the sequencer until it is idle again.
	task automatic run(input fbm_op_t op, input logic [1:0] bk, input logic bm);
		int k;
		k = 0;
		wr(FBM_REG_CTRL, {26'h0, bm, bk, op});
		repeat (3) @(posedge core_clk);
		do begin
			rd(FBM_REG_STATUS, v);
			k++;
		end while (v[FBM_ST_SEQ] !== 1'b0 && k < 500);
		`CHK("sequencer idle", 1'b0, v[FBM_ST_SEQ])
	endtask

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#400000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		reg_addr = 3'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		busy = 1'b0;
		fail = 1'b0;
		n_fail = 0;
		total_checks = 0;
		rst_b = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		`CHK("ce_n idle", 1'b1, pin_ce_n)
		rd(FBM_REG_STATUS, v);
		`CHK("status after reset", 32'h0, v)
		wr(FBM_REG_ADDR, 32'h00001234);
		run(FBM_OP_READ, 2'd0, 1'b0);
		rd(FBM_REG_RDATA, v);
		`CHK("array read", 32'h0000B7F7, v)
		$display("test reset_read done");

		wr(FBM_REG_ADDR, 32'h00100010);
		run(FBM_OP_AUTOSEL, 2'd1, 1'b0);
		`CHK("bank1 autoselect", 4'b0010, as_mode)
		`CHK("status bank flags", 4'b0010, v[FBM_ST_AS_LSB +: 4])
		repeat (2) begin
			run(FBM_OP_ASREAD, 2'd1, 1'b0);
			rd(FBM_REG_RDATA, v);
			`CHK("id read", 32'h000000A1, v)
		end
		wr(FBM_REG_ADDR, 32'h00000055);
		run(FBM_OP_READ, 2'd0, 1'b0);
		rd(FBM_REG_RDATA, v);
		`CHK("other bank array", 32'h0000A596, v)
		wr(FBM_REG_WDATA, 32'h00001234);
		run(FBM_OP_RAWWR, 2'd0, 1'b0);
		`CHK("raw write taken", 1'b0, v[FBM_ST_REF])
		rd(FBM_REG_WDATA, v);
		`CHK("wdata readback", 32'h00001234, v)
		wr(FBM_REG_ADDR, 32'h00100010);
		run(FBM_OP_READ, 2'd1, 1'b0);
		`CHK("read refused", 1'b1, v[FBM_ST_REF])
		wr(FBM_REG_STATUS, 32'h0000003C);
		$display("test autoselect done");

		run(FBM_OP_RESET, 2'd1, 1'b0);
		`CHK("modes cleared", 4'b0000, as_mode)
		`CHK("flags cleared", 4'b0000, v[FBM_ST_AS_LSB +: 4])
		run(FBM_OP_READ, 2'd1, 1'b0);
		rd(FBM_REG_RDATA, v);
		`CHK("array after reset", 32'h0000A5D3, v)
		run(FBM_OP_ASREAD, 2'd1, 1'b0);
		`CHK("asread refused", 1'b1, v[FBM_ST_REF])
		wr(FBM_REG_STATUS, 32'h0000003C);
		$display("test reset done");

		busy <= 1'b1;
		repeat (6) @(posedge core_clk);
		run(FBM_OP_AUTOSEL, 2'd2, 1'b0);
		`CHK("busy seen", 1'b1, v[FBM_ST_DEV])
		`CHK("autosel refused", 1'b1, v[FBM_ST_REF])
		`CHK("no autoselect", 4'b0000, as_mode)
		busy <= 1'b0;
		wr(FBM_REG_STATUS, 32'h0000003C);
		$display("test busy refusal done");

		for (int bm = 0; bm < 2; bm++) begin
			wr(FBM_REG_STATUS, 32'h0000003C);
			run(FBM_OP_QCHECK, 2'd0, bm[0]);
			`CHK("query done", 1'b1, v[FBM_ST_QD])
			`CHK("query match", 1'b0, v[FBM_ST_QF])
			`CHK("byte pin", ~bm[0], pin_byte_n)
		end
		$display("test query done");

		wr(FBM_REG_CTRL, 32'h0);
		fail <= 1'b1;
		@(posedge core_clk);
		fail <= 1'b0;
		repeat (5) @(posedge core_clk);
		`CHK("busy held", 1'b0, ready_busy_out_n)
		wr(FBM_REG_STATUS, 32'h0000003C);
		wr(FBM_REG_ADDR, 32'h00000055);
		run(FBM_OP_READ, 2'd0, 1'b0);
		repeat (60) @(posedge core_clk);
		rd(FBM_REG_STATUS, v);
		`CHK("timeout flag", 1'b1, v[FBM_ST_TMO])
		`CHK("reset sent", 1'b0, tmo)
		`CHK("ready again", 1'b1, ready_busy_out_n)
		wr(FBM_REG_STATUS, 32'h0000003C);
		rd(FBM_REG_STATUS, v);
		`CHK("timeout cleared", 1'b0, v[FBM_ST_TMO])
		$display("test timeout done");
		report_and_stop();
	end
endmodule // fbm_ctrl_test
`default_nettype wire
